// *** hdl/pport_top.sv ***
`timescale 1ns/100ps
`include "pport_regs.svh"
// How it works
// - Data latch resets to zero, loads on write trailing edge, drives port lines.
// - Reading the data latch returns live port line levels, not latched.
// - Status byte is snapshotted at read start and held while read lasts.
// - Overrun flag sets on EPP watchdog; reset or writing one clears it.
// - Status bits 1 and 2 always read zero.
// - Status bits 3 to 6 show fault, online, paper-out, acknowledge lines uninverted.
// - Status bit 7 shows the inverted busy input.
// - Control bits 0-5 reset; bits 6 and 7 read zero, ignore writes.
// - Control bits 0, 1, 3 drive valid, line-feed, choose outputs inverted.
// - Control bit 2 drives the printer reset output uninverted.
// - With enable bit set, acknowledge rising edge raises the interrupt request.
// - Direction bit picks in or out, except printer mode always drives.
// - With direction bit clear, offset 3 write starts address write; byte driven, latched at trailing edge.
// - Offset 3 read starts address read; data held from strobe release.
// - With direction bit clear, offset 4 write starts data write; byte driven, latched at trailing edge.
// - Offset 4 read starts data read; data held from strobe release.
// - Offsets 3 to 7 exist only in EPP mode; 0 to 2 always.
// - Reset clears the EPP address and data registers.
// - EPP watchdog aborts cycles past 10 us and sets the overrun flag.
// - Host wait line is low from EPP cycle start until handshake completes.
// - Without an EPP cycle, outputs follow the control register, and so does direction outside printer mode.
module pport_top
  import pport_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire port_mode_t i_port_mode,
  input wire logic [2:0] i_host_addr,
  input wire logic i_host_write_pulse_n,
  input wire logic i_host_read_pulse_n,
  input wire logic [7:0] i_host_data_bus,
  output logic [7:0] o_host_data_bus,
  output logic o_host_ready,
  input wire logic [7:0] i_port_data_lines,
  output logic [7:0] o_port_data_lines,
  output logic o_port_data_oe_n,
  input wire logic i_fault_line_in,
  input wire logic i_online_line_in,
  input wire logic i_paper_out_line_in,
  input wire logic i_acknowledge_line_in,
  input wire logic i_peripheral_busy,
  output logic o_data_valid_out,
  output logic o_line_feed_out,
  output logic o_printer_reset_out,
  output logic o_printer_choose_out,
  output logic o_irq
);
  localparam logic [11:0] WDOG_LIMIT = 12'(`PP_WDOG_CYC);

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic wr_q_reg;
  logic rd_q_reg;
  logic ack_q_reg;
  logic [7:0] host_data_q_reg;
  logic [2:0] addr_q_reg;
  logic wr_lead;
  logic wr_trail;
  logic rd_lead;
  logic epp_mode;
  logic epp_space;
  logic [7:0] data_reg;
  logic [5:0] ctrl_reg;
  logic overrun_reg;
  logic [7:0] epp_addr_reg;
  logic [7:0] epp_data_reg;
  logic [7:0] wbyte_reg;
  epp_state_t state_reg;
  epp_state_t state_next;
  logic [11:0] wdog_reg;
  logic wdog_fire;
  logic cyc_read_reg;
  logic cyc_addr_reg;
  logic push_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [9:0] fifo_out_data;
  logic hold_line;
  logic [7:0] status_now;
  logic valid_next;
  logic lfeed_next;
  logic choose_next;
  logic oe_n_next;
  logic [7:0] pdata_next;

  // Reset release is synchronised so that every flop reset by rst_n leaves reset on the same edge.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // Host strobe edge detection.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q_reg <= 1'b1;
      rd_q_reg <= 1'b1;
      ack_q_reg <= 1'b1;
      host_data_q_reg <= 8'h00;
      addr_q_reg <= 3'h0;
    end else begin
      wr_q_reg <= i_host_write_pulse_n;
      rd_q_reg <= i_host_read_pulse_n;
      ack_q_reg <= i_acknowledge_line_in;
      if (!i_host_write_pulse_n) begin
        host_data_q_reg <= i_host_data_bus;
      end
      if (wr_lead || rd_lead) begin
        addr_q_reg <= i_host_addr;
      end
    end
  end

  assign wr_lead = wr_q_reg && !i_host_write_pulse_n;
  assign wr_trail = !wr_q_reg && i_host_write_pulse_n;
  assign rd_lead = rd_q_reg && !i_host_read_pulse_n;
  assign epp_mode = (i_port_mode == MODE_EPP);
  assign epp_space = epp_mode && (i_host_addr >= `PP_OFF_EADDR);
  // busy pin is the wait line
  assign hold_line = i_peripheral_busy;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= `PP_DATA_RST;
    end else if (wr_trail && addr_q_reg == `PP_OFF_DATA) begin
      data_reg <= host_data_q_reg;
    end
  end

  // only six control bits are stored
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `PP_CTRL_RST;
    end else if (wr_trail && addr_q_reg == `PP_OFF_CTRL) begin
      ctrl_reg <= host_data_q_reg[5:0];
    end
  end

  // set wins over a simultaneous clear
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (wdog_fire) begin
      overrun_reg <= 1'b1;
    end else if (wr_trail && addr_q_reg == `PP_OFF_STAT && host_data_q_reg[`PP_ST_OVERRUN]) begin
      overrun_reg <= 1'b0;
    end
  end

  // writes and reads above offset 2 queue nothing outside EPP mode
  assign push_valid = (wr_lead || rd_lead) && epp_space && fifo_in_ready;

  // Each EPP request is queued with its kind; the engine drains one at a time
  // because the host is stalled on the wait line until its cycle completes.
  pport_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH)
  ) u_req_fifo (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_in_valid(push_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data({rd_lead, i_host_addr == `PP_OFF_EADDR, i_host_data_bus}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  assign fifo_out_ready = (state_reg == ST_IDLE);

  // watchdog expires while the handshake is still open
  assign wdog_fire = (state_reg == ST_SYNC || state_reg == ST_STROBE) && (wdog_reg >= WDOG_LIMIT);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (fifo_out_valid) begin
          state_next = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (wdog_fire) begin
          state_next = ST_HOLD;
        end else if (!hold_line) begin
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (wdog_fire || hold_line) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (i_host_write_pulse_n && i_host_read_pulse_n) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // counts from cycle start in ST_SYNC, before the strobe, to wait release
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_reg <= 12'h000;
    end else if (state_reg == ST_SYNC || state_reg == ST_STROBE) begin
      wdog_reg <= wdog_reg + 12'h001;
    end else begin
      wdog_reg <= 12'h000;
    end
  end

  // A write with the direction bit at one cannot drive, so it runs as a read.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_read_reg <= 1'b0;
      cyc_addr_reg <= 1'b0;
      wbyte_reg <= 8'h00;
    end else if (state_reg == ST_IDLE && fifo_out_valid) begin
      cyc_read_reg <= fifo_out_data[9] || ctrl_reg[`PP_CT_DIR];
      cyc_addr_reg <= fifo_out_data[8];
      wbyte_reg <= fifo_out_data[7:0];
    end else if (state_reg != ST_IDLE && !cyc_read_reg && !i_host_write_pulse_n) begin
      // byte follows the host until the trailing edge latches it
      wbyte_reg <= i_host_data_bus;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      epp_addr_reg <= `PP_EPP_RST;
      epp_data_reg <= `PP_EPP_RST;
    end else if (state_reg == ST_STROBE && state_next == ST_HOLD && cyc_read_reg) begin
      // address read sampled at strobe release
      if (cyc_addr_reg) begin
        epp_addr_reg <= i_port_data_lines;
      end else begin
        // data read sampled at strobe release
        epp_data_reg <= i_port_data_lines;
      end
    end else if (wr_trail && state_reg != ST_IDLE && !cyc_read_reg) begin
      // write byte latched at trailing edge
      if (cyc_addr_reg) begin
        epp_addr_reg <= host_data_q_reg;
      end else begin
        epp_data_reg <= host_data_q_reg;
      end
    end
  end

  // host wait held low from request until the engine releases it
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_host_ready <= 1'b1;
    end else if (push_valid) begin
      o_host_ready <= 1'b0;
    end else if (state_reg != ST_HOLD && state_next == ST_HOLD) begin
      o_host_ready <= 1'b1;
    end
  end

  // bits 1 and 2 are zero
  assign status_now = {!i_peripheral_busy, i_acknowledge_line_in, i_paper_out_line_in,
                       i_online_line_in, i_fault_line_in, 2'b00, overrun_reg};

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_host_data_bus <= 8'h00;
    end else if (rd_lead) begin
      case (i_host_addr)
        `PP_OFF_DATA: o_host_data_bus <= i_port_data_lines;
        `PP_OFF_STAT: o_host_data_bus <= status_now;
        `PP_OFF_CTRL: o_host_data_bus <= {2'b00, ctrl_reg};
        default: o_host_data_bus <= 8'h00;
      endcase
    end else if (!i_host_read_pulse_n) begin
      if (addr_q_reg == `PP_OFF_DATA) begin
        // unlatched buffer of the port lines
        o_host_data_bus <= i_port_data_lines;
      end else if (state_reg == ST_STROBE && state_next == ST_HOLD && cyc_read_reg) begin
        o_host_data_bus <= i_port_data_lines;
      end else if (addr_q_reg >= `PP_OFF_EADDR && !epp_mode) begin
        o_host_data_bus <= 8'h00;
      end
    end else begin
      o_host_data_bus <= 8'h00;
    end
  end

  // Pin drive: EPP cycle ownership first, then the control register.
  always_comb begin
    if (state_reg != ST_IDLE) begin
      // write line, data strobe and address strobe
      valid_next = cyc_read_reg;
      lfeed_next = !(state_reg == ST_STROBE && !cyc_addr_reg);
      choose_next = !(state_reg == ST_STROBE && cyc_addr_reg);
      oe_n_next = cyc_read_reg;
      pdata_next = wbyte_reg;
    end else begin
      valid_next = !ctrl_reg[`PP_CT_VALID];
      lfeed_next = !ctrl_reg[`PP_CT_LFEED];
      choose_next = !ctrl_reg[`PP_CT_CHOOSE];
      oe_n_next = (i_port_mode == MODE_PRINTER) ? 1'b0 : ctrl_reg[`PP_CT_DIR];
      pdata_next = data_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_data_valid_out <= 1'b1;
      o_line_feed_out <= 1'b1;
      o_printer_choose_out <= 1'b1;
      o_printer_reset_out <= 1'b0;
      o_port_data_oe_n <= 1'b0;
      o_port_data_lines <= 8'h00;
    end else begin
      o_data_valid_out <= valid_next;
      o_line_feed_out <= lfeed_next;
      o_printer_choose_out <= choose_next;
      o_printer_reset_out <= ctrl_reg[`PP_CT_RESET];
      o_port_data_oe_n <= oe_n_next;
      o_port_data_lines <= pdata_next;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= ctrl_reg[`PP_CT_IRQEN] && !ack_q_reg && i_acknowledge_line_in;
    end
  end
endmodule

// *** hdl/pport_regs.svh ***
`ifndef PPORT_REGS_SVH
`define PPORT_REGS_SVH

// Register offsets from the port base.
`define PP_OFF_DATA 3'h0
`define PP_OFF_STAT 3'h1
`define PP_OFF_CTRL 3'h2
`define PP_OFF_EADDR 3'h3
`define PP_OFF_EDATA0 3'h4
`define PP_OFF_EDATA1 3'h5
`define PP_OFF_EDATA2 3'h6
`define PP_OFF_EDATA3 3'h7

// Status field positions.
`define PP_ST_OVERRUN 0
`define PP_ST_FAULT 3
`define PP_ST_ONLINE 4
`define PP_ST_PAPER 5
`define PP_ST_ACK 6
`define PP_ST_READY 7

// Control field positions.
`define PP_CT_VALID 0
`define PP_CT_LFEED 1
`define PP_CT_RESET 2
`define PP_CT_CHOOSE 3
`define PP_CT_IRQEN 4
`define PP_CT_DIR 5

// Reset values.
`define PP_DATA_RST 8'h00
`define PP_CTRL_RST 6'h00
`define PP_EPP_RST 8'h00

// Watchdog timing.
`define PP_WDOG_NS 10000
`define PP_CLK_NS 4
`define PP_WDOG_CYC (`PP_WDOG_NS / `PP_CLK_NS)

`endif

// *** hdl/pport_pkg.sv ***
package pport_pkg;

  typedef enum logic [1:0] {
    MODE_PRINTER = 2'b00,
    MODE_BIDIR = 2'b01,
    MODE_EPP = 2'b10
  } port_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD = 2'b11
  } epp_state_t;

endpackage

// *** hdl/pport_fifo.sv ***
`timescale 1ns/100ps
module pport_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// *** testbench/pport_periph_model.sv ***
`timescale 1ns/100ps
module pport_periph_model (
  input wire logic i_clk,
  input wire logic [7:0] i_lines,
  input wire logic i_write_n,
  input wire logic i_dstrb_n,
  input wire logic i_astrb_n,
  input wire logic [3:0] i_delay,
  input wire logic i_stall,
  input wire logic [7:0] i_rd_byte,
  output logic [7:0] o_lines,
  output logic o_wait,
  output logic [7:0] o_got,
  output logic o_was_addr
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    o_lines = 8'h00;
    o_wait = 1'b0;
    o_got = 8'h00;
    o_was_addr = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_dstrb_n && i_astrb_n) begin
      cnt <= 4'h0;
      o_wait <= 1'b0;
    end else if (!i_stall && cnt == i_delay) begin
      o_wait <= 1'b1;
      o_got <= i_lines;
      o_was_addr <= !i_astrb_n;
    end else begin
      cnt <= cnt + 4'h1;
    end
    // Released lines toggle so a stale value is never mistaken for data.
    o_lines <= (!(i_dstrb_n && i_astrb_n) && i_write_n) ? i_rd_byte : ~o_lines;
  end
endmodule

// *** testbench/pport_top_sva.sv ***
`timescale 1ns/100ps
`include "pport_regs.svh"
module pport_top_sva
  import pport_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire port_mode_t i_port_mode,
  input wire logic [2:0] i_host_addr,
  input wire logic i_host_write_pulse_n,
  input wire logic i_host_read_pulse_n,
  input wire logic [7:0] o_host_data_bus,
  input wire logic o_host_ready,
  input wire logic o_port_data_oe_n,
  input wire logic o_data_valid_out,
  input wire logic o_line_feed_out,
  input wire logic i_acknowledge_line_in,
  input wire logic i_peripheral_busy,
  input wire logic o_irq
);
  localparam int WDOG_MAX = 2510;
  int lo_cnt;
  // Length of the current stretch, so the watchdog bound needs no long repetition.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lo_cnt <= 0;
    end else if (o_host_ready) begin
      lo_cnt <= 0;
    end else begin
      lo_cnt <= lo_cnt + 1;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  AST_IDLE_READY:
    assert property (i_port_mode != MODE_EPP |-> o_host_ready)
    else $error("host stretched outside EPP mode");
  AST_STAT_ZERO:
    assert property ((!i_host_read_pulse_n && i_host_addr == `PP_OFF_STAT)[*3] |-> o_host_data_bus[2:1] == 2'b00)
    else $error("status bits 1 and 2 not zero");
  AST_STAT_HOLD:
    assert property ((!i_host_read_pulse_n && i_host_addr == `PP_OFF_STAT)[*4] |-> $stable(o_host_data_bus))
    else $error("status changed during a read");
  AST_PRINTER_DRIVES:
    assert property (i_port_mode == MODE_PRINTER && $past(i_port_mode) == MODE_PRINTER |-> !o_port_data_oe_n)
    else $error("printer mode released the data lines");
  AST_STRETCH_CAUSE:
    assert property ($fell(o_host_ready) |-> i_port_mode == MODE_EPP
      && (!$past(i_host_write_pulse_n) || !$past(i_host_read_pulse_n)))
    else $error("stretch without a host strobe");
  AST_WATCHDOG:
    assert property (lo_cnt < WDOG_MAX)
    else $error("stretch outlived the watchdog");
  AST_RELEASE_CAUSE:
    assert property ($rose(o_host_ready) |-> $past(i_peripheral_busy) || lo_cnt > 2400)
    else $error("stretch ended before the peripheral released wait");
  AST_WRITE_DRIVES:
    assert property (!o_host_ready && !o_line_feed_out && !o_data_valid_out |-> !o_port_data_oe_n)
    else $error("write strobe without driven data");
  AST_IRQ_PULSE:
    assert property (o_irq |=> !o_irq)
    else $error("interrupt longer than one cycle");
  AST_IRQ_CAUSE:
    assert property (o_irq |-> $past(i_acknowledge_line_in))
    else $error("interrupt without acknowledge");
  COV_EPP_DONE: cover property (!o_host_ready ##1 o_host_ready);
  COV_IRQ: cover property (o_irq);
  COV_ABORT: cover property (lo_cnt > 2400);
endmodule

// *** testbench/pport_top_test.sv ***
`timescale 1ns/100ps
`include "pport_regs.svh"
module pport_top_test;
  import pport_pkg::*;
  logic clk = 0, arst_n = 0, wr_n = 1, rd_n = 1, fault = 0, online = 0, paper = 0, ack = 0, spp_busy = 0, stall = 0;
  port_mode_t mode = MODE_PRINTER;
  logic [2:0] addr = 3'h0, a;
  logic [7:0] hdata = 8'h00, rd_byte = 8'h00, m_lines, dout, plines, lines, got, v, s, dl;
  logic [3:0] dly = 4'h0;
  logic m_wait, busy, oe_n, dv, lf, pr, ch, irq, rdy, m_addr;
  int num_errors = 0, n_checks = 0, irqs = 0, n, seed = 32'h5a70;
  always #2 clk = ~clk;
  assign lines = oe_n ? m_lines : plines;
  // The peripheral owns the busy pin as its wait line only in EPP mode.
  assign busy = (mode == MODE_EPP) ? m_wait : spp_busy;
  always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
  pport_top i_dut (.i_core_clk(clk), .i_arst_n(arst_n), .i_port_mode(mode), .i_host_addr(addr),
    .i_host_write_pulse_n(wr_n), .i_host_read_pulse_n(rd_n), .i_host_data_bus(hdata), .o_host_data_bus(dout),
    .o_host_ready(rdy), .i_port_data_lines(lines), .o_port_data_lines(plines), .o_port_data_oe_n(oe_n),
    .i_fault_line_in(fault), .i_online_line_in(online), .i_paper_out_line_in(paper),
    .i_acknowledge_line_in(ack), .i_peripheral_busy(busy), .o_data_valid_out(dv), .o_line_feed_out(lf),
    .o_printer_reset_out(pr), .o_printer_choose_out(ch), .o_irq(irq));
  pport_periph_model i_per (.i_clk(clk), .i_lines(lines), .i_write_n(dv), .i_dstrb_n(lf), .i_astrb_n(ch),
    .i_delay(dly), .i_stall(stall), .i_rd_byte(rd_byte), .o_lines(m_lines), .o_wait(m_wait), .o_got(got),
    .o_was_addr(m_addr));
  function automatic logic [7:0] pins_exp(input logic [7:0] c);
    return {4'h0, ~c[0], ~c[1], c[2], ~c[3]};
  endfunction
  function automatic logic [7:0] stat_exp(input logic [7:0] x);
    return {~x[0], 1'b1, x[1], x[2], x[3], 3'h0};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [2:0] ad, input logic [7:0] d, output logic [7:0] q);
    int k;
    @(posedge clk);
    addr <= ad;
    hdata <= d;
    if (wr) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while ((rdy !== 1'b1 || k < 4) && k < 3000);
    chk("host ready", {7'h0, rdy}, 8'h01);
    q = dout;
    @(posedge clk);
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    // A trailing-edge write reaches the registered pins two edges after release, so wait for a third.
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, `PP_OFF_CTRL, 8'h00, v);
    chk("control", v, 8'h00);
    chk("pins", {4'h0, dv, lf, pr, ch}, pins_exp(8'h00));
    chk("data lines", plines, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 8'hff : 8'($random(seed));
      dl = ~s;
      bus(1, `PP_OFF_CTRL, s, v);
      bus(0, `PP_OFF_CTRL, 8'h00, v);
      chk("control", v, s & 8'h3f);
      chk("pins", {4'h0, dv, lf, pr, ch}, pins_exp(s));
      chk("oe_n", {7'h0, oe_n}, 8'h00);
      bus(1, `PP_OFF_DATA, dl, v);
      bus(0, `PP_OFF_DATA, 8'h00, v);
      chk("data read", v, dl);
    end
    $display("test control and data done");
    mode <= MODE_BIDIR;
    for (int i = 0; i < 6; i++) begin
      s = 8'($random(seed));
      bus(1, `PP_OFF_CTRL, {3'h1, i[0], 4'h0}, v);
      chk("oe_n", {7'h0, oe_n}, 8'h01);
      {fault, online, paper, spp_busy} <= s[3:0];
      ack <= 1'b0;
      repeat (4) @(posedge clk);
      n = irqs;
      ack <= 1'b1;
      repeat (6) @(posedge clk);
      chk("irq count", 8'(irqs - n), {7'h0, i[0]});
      bus(0, `PP_OFF_STAT, 8'h00, v);
      chk("status", v, stat_exp(s));
    end
    // The fault line moves in mid-read; the snapshot taken at the leading edge must not follow it.
    fork
      bus(0, `PP_OFF_STAT, 8'h00, v);
      begin
        repeat (3) @(posedge clk);
        fault <= ~fault;
      end
    join
    chk("status hold", v, stat_exp(s));
    bus(1, `PP_OFF_EDATA1, 8'h77, v);
    chk("data lines", plines, dl);
    bus(0, `PP_OFF_EDATA2, 8'h00, v);
    chk("epp read off", v, 8'h00);
    $display("test status and interrupt done");
    mode <= MODE_EPP;
    bus(1, `PP_OFF_CTRL, 8'h04, v);
    for (int i = 0; i < 12; i++) begin
      s = 8'($random(seed));
      a = 3'h3 + 3'(i % 5);
      dly <= i[2] ? 4'($random(seed)) : 4'h0;
      rd_byte <= ~s;
      if (i[1]) begin
        bus(0, a, 8'h00, v);
        chk("epp read", v, ~s);
      end else begin
        bus(1, a, s, v);
        chk("epp byte", got, s);
        chk("strobe kind", {7'h0, m_addr}, {7'h0, a == 3'h3});
      end
    end
    $display("test epp cycles done");
    stall <= 1'b1;
    bus(1, `PP_OFF_EDATA0, 8'h5a, v);
    stall <= 1'b0;
    bus(0, `PP_OFF_STAT, 8'h00, v);
    chk("overrun", v & 8'h01, 8'h01);
    bus(1, `PP_OFF_STAT, 8'hfe, v);
    bus(0, `PP_OFF_STAT, 8'h00, v);
    chk("overrun", v & 8'h01, 8'h01);
    bus(1, `PP_OFF_STAT, 8'h01, v);
    bus(0, `PP_OFF_STAT, 8'h00, v);
    chk("overrun", v & 8'h01, 8'h00);
    $display("test overrun done");
    close_out();
  end
endmodule
bind pport_top pport_top_sva i_sva (.i_core_clk, .i_arst_n, .i_port_mode, .i_host_addr, .i_host_write_pulse_n,
  .i_host_read_pulse_n, .o_host_data_bus, .o_host_ready, .o_port_data_oe_n, .o_data_valid_out,
  .o_line_feed_out, .i_acknowledge_line_in, .i_peripheral_busy, .o_irq);
